// ### design/gp_port.sv
// eight-pin general purpose port: control bits, latch, pin drive and readback
`timescale 1ns/1ps
module gp_port
    import gp_pkg::*;
#(
    parameter int WIDTH = GP_WIDTH
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire gp_sel_t wr_sel_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] wr_mask_i,
    input wire logic [7:0] pin_in_i,
    output logic [7:0] pin_out_o,
    output logic [7:0] pin_oe_o,
    output logic [7:0] port_pin_data_o,
    output logic [7:0] output_data_latch_o,
    output logic [7:0] pin_direction_select_o,
    output logic [7:0] analog_mode_select_o,
    output gp_pad_cfg_t pad_cfg_o
);
    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    // the pin vectors are fixed at eight bits; any other width is refused
    if (WIDTH != GP_WIDTH) begin : g_width_chk
        $error("gp_port serves eight pins only");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] dir_r;
    logic [7:0] dir_nxt;
    logic [7:0] lat_r;
    logic [7:0] lat_nxt;
    logic [7:0] ana_r;
    logic [7:0] ana_nxt;
    logic [7:0] od_r;
    logic [7:0] od_nxt;
    logic [7:0] slew_r;
    logic [7:0] slew_nxt;
    logic [7:0] thr_r;
    logic [7:0] thr_nxt;
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;
    logic [7:0] oe_r;
    logic [7:0] oe_nxt;
    logic [7:0] out_r;
    logic [7:0] out_nxt;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // masked merge shared by every register write
    function automatic logic [7:0] merge(
        input logic [7:0] old_v,
        input logic [7:0] new_v,
        input logic [7:0] mask
    );
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // write strobe decode for one target register
    function automatic logic sel_hit(
        input logic en,
        input gp_sel_t sel,
        input gp_sel_t target
    );
        sel_hit = en && (sel == target);
    endfunction

    // open drain releases the pin for a latch one, so the enable carries the level
    function automatic logic [7:0] drive_enable(
        input logic [7:0] dir_v,
        input logic [7:0] od_v,
        input logic [7:0] lat_v
    );
        drive_enable = ~dir_v & ~(od_v & lat_v);
    endfunction

    // an open-drain pin only ever pulls low
    function automatic logic [7:0] drive_level(
        input logic [7:0] dir_v,
        input logic [7:0] od_v,
        input logic [7:0] lat_v
    );
        drive_level = lat_v & ~od_v & ~dir_v;
    endfunction

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    wire wr_pin = sel_hit(wr_en_i, wr_sel_i, GP_SEL_PIN_DATA);
    wire wr_lat = sel_hit(wr_en_i, wr_sel_i, GP_SEL_LATCH);
    wire wr_dir = sel_hit(wr_en_i, wr_sel_i, GP_SEL_DIRECTION);
    wire wr_od = sel_hit(wr_en_i, wr_sel_i, GP_SEL_OPEN_DRAIN);
    wire wr_slew = sel_hit(wr_en_i, wr_sel_i, GP_SEL_SLEW);
    wire wr_thr = sel_hit(wr_en_i, wr_sel_i, GP_SEL_THRESHOLD);
    wire wr_ana = sel_hit(wr_en_i, wr_sel_i, GP_SEL_ANALOG);
    // the unused select code matches no target, so such a write changes nothing

    // ----------------------------------------------------------------
    // readback
    // ----------------------------------------------------------------
    // threshold choice is made in the analog pad; the core sees the resolved level
    wire [7:0] digital_in = pin_in_i & ~ana_r;
    // the readback flop costs one cycle of lag but keeps the data output registered
    assign rd_nxt = digital_in;

    // ----------------------------------------------------------------
    // output latch
    // ----------------------------------------------------------------
    // analog pins sample as zero here too, so a write can clear their latch bits
    wire [7:0] lat_wr_pin = merge(digital_in, wr_data_i, wr_mask_i);
    wire [7:0] lat_wr_lat = merge(lat_r, wr_data_i, wr_mask_i);
    assign lat_nxt = wr_pin ? lat_wr_pin :
                     wr_lat ? lat_wr_lat :
                     lat_r;

    // ----------------------------------------------------------------
    // direction and analog select
    // ----------------------------------------------------------------
    wire [7:0] dir_wr = merge(dir_r, wr_data_i, wr_mask_i);
    wire [7:0] ana_wr = merge(ana_r, wr_data_i, wr_mask_i);
    assign dir_nxt = wr_dir ? dir_wr : dir_r;
    assign ana_nxt = wr_ana ? ana_wr : ana_r;

    // ----------------------------------------------------------------
    // pad configuration
    // ----------------------------------------------------------------
    wire [7:0] od_wr = merge(od_r, wr_data_i, wr_mask_i);
    wire [7:0] slew_wr = merge(slew_r, wr_data_i, wr_mask_i);
    wire [7:0] thr_wr = merge(thr_r, wr_data_i, wr_mask_i);
    assign od_nxt = wr_od ? od_wr : od_r;
    assign slew_nxt = wr_slew ? slew_wr : slew_r;
    // a change here can glitch the pad input; software keeps peripherals off meanwhile
    assign thr_nxt = wr_thr ? thr_wr : thr_r;

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    // built from next values, so the drive flops move at the same edge as the latch
    assign oe_nxt = drive_enable(dir_nxt, od_nxt, lat_nxt);
    assign out_nxt = drive_level(dir_nxt, od_nxt, lat_nxt);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            dir_r <= GP_DIR_RST;
        end else begin
            dir_r <= dir_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            lat_r <= GP_LAT_RST;
        end else begin
            lat_r <= lat_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ana_r <= GP_ANA_RST;
        end else begin
            ana_r <= ana_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            od_r <= GP_OD_RST;
        end else begin
            od_r <= od_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            slew_r <= GP_SLEW_RST;
        end else begin
            slew_r <= slew_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            thr_r <= GP_THR_RST;
        end else begin
            thr_r <= thr_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rd_r <= GP_RD_RST;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            oe_r <= drive_enable(GP_DIR_RST, GP_OD_RST, GP_LAT_RST);
        end else begin
            oe_r <= oe_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            out_r <= drive_level(GP_DIR_RST, GP_OD_RST, GP_LAT_RST);
        end else begin
            out_r <= out_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pin_out_o = out_r;
    assign pin_oe_o = oe_r;
    assign port_pin_data_o = rd_r;
    assign output_data_latch_o = lat_r;
    assign pin_direction_select_o = dir_r;
    assign analog_mode_select_o = ana_r;
    assign pad_cfg_o = '{od_r, slew_r, thr_r};
endmodule

// ### design/gp_pkg.sv
// package for the eight-pin general purpose port: types, reset values, access codes
package gp_pkg;
    localparam int GP_WIDTH = 8;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] GP_DIR_RST = 8'hff;
    localparam logic [7:0] GP_LAT_RST = 8'h00;
    localparam logic [7:0] GP_OD_RST = 8'h00;
    localparam logic [7:0] GP_SLEW_RST = 8'hff;
    localparam logic [7:0] GP_THR_RST = 8'hff;
    localparam logic [7:0] GP_ANA_RST = 8'hff;
    localparam logic [7:0] GP_RD_RST = 8'h00;

    // ----------------------------------------------------------------
    // register selection for the write port
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        GP_SEL_PIN_DATA,
        GP_SEL_LATCH,
        GP_SEL_DIRECTION,
        GP_SEL_OPEN_DRAIN,
        GP_SEL_SLEW,
        GP_SEL_THRESHOLD,
        GP_SEL_ANALOG
    } gp_sel_t;

    typedef struct packed {
        logic [7:0] open_drain_select;
        logic [7:0] slew_limit_select;
        logic [7:0] input_threshold_select;
    } gp_pad_cfg_t;
endpackage

// ### dv/gp_board.sv
// board model that drives or reads the port pins from outside
`timescale 1ns/1ps
module gp_board (
    input wire logic [7:0] pin_drv_i,
    input wire logic [7:0] pin_en_i,
    input wire logic [7:0] ext_lvl_i,
    output logic [7:0] pin_lvl_o
);
    // released pins show the board level, so a stale port value cannot pass
    assign pin_lvl_o = (pin_en_i & pin_drv_i) | (~pin_en_i & ext_lvl_i);
endmodule

// ### dv/gp_port_checker.sv
// assertion checker for the eight-pin port
`timescale 1ns/1ps
module gp_port_checker import gp_pkg::*; (
    input wire logic core_clk_i, rst_n_i, wr_en_i,
    input wire gp_sel_t wr_sel_i,
    input wire logic [7:0] wr_data_i, wr_mask_i, pin_in_i, pin_out_o, pin_oe_o, port_pin_data_o,
    input wire logic [7:0] output_data_latch_o, pin_direction_select_o, analog_mode_select_o,
    input wire gp_pad_cfg_t pad_cfg_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic [7:0] lat = output_data_latch_o, dir = pin_direction_select_o;
    wire logic [7:0] dig = pin_in_i & ~analog_mode_select_o;
    wire logic [7:0] rmw_v = (dig & ~wr_mask_i) | (wr_data_i & wr_mask_i);
    wire logic [7:0] lat_v = (lat & ~wr_mask_i) | (wr_data_i & wr_mask_i);
    wire logic [7:0] dir_v = (dir & ~wr_mask_i) | (wr_data_i & wr_mask_i);
    sequence pd_wr; wr_en_i && wr_sel_i == GP_SEL_PIN_DATA; endsequence
    sequence lat_wr; wr_en_i && wr_sel_i == GP_SEL_LATCH; endsequence
    dir_off_a: assert property ((pin_oe_o & dir) == 8'h00) else $error("input pin driven");
    drive_lat_a: assert property (pin_oe_o == (~dir & ~(pad_cfg_o.open_drain_select & lat))
        && (pin_oe_o & (pin_out_o ^ lat)) == 8'h00) else $error("bad pin drive");
    read_pin_a: assert property (port_pin_data_o == $past(dig)) else $error("bad pin read");
    rmw_wr_a: assert property (pd_wr |=> lat == $past(rmw_v)) else $error("bad rmw");
    lat_wr_a: assert property (lat_wr |=> lat == $past(lat_v)) else $error("bad latch");
    lat_hold_a: assert property ((!wr_en_i || wr_sel_i > GP_SEL_LATCH) |=> $stable(lat))
        else $error("latch moved");
    dir_wr_a: assert property (wr_en_i && wr_sel_i == GP_SEL_DIRECTION |=> dir == $past(dir_v))
        else $error("bad direction");
    rst_val_a: assert property (disable iff (1'b0) !rst_n_i |=> dir == 8'hff
        && analog_mode_select_o == 8'hff && lat == 8'h00) else $error("bad reset value");
endmodule
bind gp_port gp_port_checker i_gp_port_checker (.*);

// ### dv/tb.sv
// self-checking bench for the eight-pin port
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED %0t %h vs %h", $time, a, b); end end
module tb import gp_pkg::*; ;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, wr_en_i = 1'b0;
    gp_sel_t wr_sel_i = GP_SEL_PIN_DATA;
    logic [7:0] wr_data_i = 8'h00, wr_mask_i = 8'h00, ext = 8'h00, pin_in_i, pin_out_o, pin_oe_o;
    logic [7:0] port_pin_data_o, output_data_latch_o, pin_direction_select_o, analog_mode_select_o;
    gp_pad_cfg_t pad_cfg_o;
    int error_cnt = 0, checks_done = 0;
    wire logic [7:0] dir = pin_direction_select_o, ana = analog_mode_select_o;
    wire logic [7:0] lat = output_data_latch_o;
    always #50 core_clk_i = ~core_clk_i;
    gp_port i_gp_port (.*);
    gp_board i_gp_board (.pin_drv_i(pin_out_o), .pin_en_i(pin_oe_o), .ext_lvl_i(ext),
        .pin_lvl_o(pin_in_i));
    task automatic wr(input gp_sel_t s, input logic [7:0] d, input logic [7:0] m);
        @(posedge core_clk_i) {wr_en_i, wr_sel_i, wr_data_i, wr_mask_i} <= {1'b1, s, d, m};
        @(posedge core_clk_i) wr_en_i <= 1'b0;
        #1;
    endtask
    task automatic t_rmw;
        wr(GP_SEL_ANALOG, 8'h00, 8'hff);
        wr(GP_SEL_THRESHOLD, 8'h00, 8'hff);
        ext <= 8'ha5;
        wr(GP_SEL_DIRECTION, 8'h00, 8'h0f);
        wr(GP_SEL_PIN_DATA, 8'h03, 8'h03);
        `CHK({lat, pin_oe_o, pin_out_o}, {8'ha3, 8'h0f, 8'h03})
        @(posedge core_clk_i) #1;
        `CHK(port_pin_data_o, 8'ha3)
        wr(GP_SEL_LATCH, 8'h50, 8'hf0);
        // pins read a3 now, so a latch write that sampled them would lose the 5
        wr(GP_SEL_LATCH, 8'hff, 8'h00);
        `CHK(lat, 8'h53)
    endtask
    task automatic t_ana;
        wr(GP_SEL_ANALOG, 8'h81, 8'hff);
        @(posedge core_clk_i) #1;
        `CHK(port_pin_data_o, 8'h22)
        `CHK({pin_oe_o, pin_out_o}, {8'h0f, 8'h03})
    endtask
    task automatic t_od;
        wr(GP_SEL_OPEN_DRAIN, 8'hff, 8'h0f);
        `CHK({pin_oe_o, pin_out_o}, {8'h0c, 8'h00})
        wr(GP_SEL_SLEW, 8'h00, 8'h0f);
        wr(gp_sel_t'(3'h7), 8'h00, 8'hff);
        `CHK({dir, ana, lat, pad_cfg_o}, {8'hf0, 8'h81, 8'h53, 24'h0f_f000})
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (19) @(posedge core_clk_i);
        #1;
        `CHK({dir, ana, lat, pin_oe_o, pad_cfg_o}, {24'hff_ff00, 8'h00, 24'h00_ffff})
        @(posedge core_clk_i) rst_n_i <= 1'b1;
        t_rmw();
        t_ana();
        t_od();
        complete_run();
    end
endmodule
